// [gisp_pkg.sv]
// package of constants and carrier types for the two-wire slave port
package gisp_pkg;
  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h55;      // 1010101, gives 0xAA write, 0xAB read
  localparam logic [7:0] CMD_READ_MAX = 8'h7F;    // highest readable location
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int STUCK_BUS_TIMEOUT_S = 2;
  localparam int STUCK_BUS_TIMEOUT_CYC = STUCK_BUS_TIMEOUT_S * CLK_HZ;
  localparam int TMO_W = 25;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] BITCNT_RST = 4'h0;
  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // synchronised bus line levels and edges
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } gisp_line_t;

  // access toward the command map
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } gisp_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRX = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101,
    ST_HOLD = 3'b110
  } gisp_state_t;
endpackage

// [gisp_line_sync.sv]
// two-flop synchroniser and edge/condition detector for the bus lines
`timescale 1ns/1ps
module gisp_line_sync (
  // clock and control
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // raw bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // conditioned lines
  output gisp_pkg::gisp_line_t o_line
);
  logic [1:0] s1_reg, s1_next;
  logic [1:0] s2_reg, s2_next;
  logic [1:0] s3_reg, s3_next;
  gisp_pkg::gisp_line_t line_next;

  // sync chain; the third stage gives the previous level for edges
  always_comb begin
    s1_next = {i_scl, i_sda};
    s2_next = s1_reg;
    s3_next = s2_reg;
    line_next.scl = s2_reg[1];
    line_next.sda = s2_reg[0];
    line_next.scl_rise = s2_reg[1] & ~s3_reg[1];
    line_next.scl_fall = ~s2_reg[1] & s3_reg[1];
    line_next.start = s2_reg[1] & s3_reg[1] & ~s2_reg[0] & s3_reg[0];
    line_next.stop = s2_reg[1] & s3_reg[1] & s2_reg[0] & ~s3_reg[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
      s3_reg <= 2'h3;
      o_line <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};  // idle bus reads high
    end else if (i_ce) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      o_line <= line_next;
    end
  end
endmodule

// [gisp_slave.sv]
// two-wire slave port engine with pointer, acknowledge policy and stuck-bus release
`timescale 1ns/1ps
module gisp_slave #(
  parameter int TIMEOUT_CYC = gisp_pkg::STUCK_BUS_TIMEOUT_CYC
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // bus pins (open drain)
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  // command map side
  input wire logic [7:0] i_rdata,
  input wire logic i_ro,
  output gisp_pkg::gisp_cmd_t o_cmd,
  output logic [7:0] o_ptr,
  // status
  output logic o_sleep,
  output logic o_two_wire_mode
);
  localparam int TMO_W = gisp_pkg::TMO_W;
  gisp_pkg::gisp_line_t line;
  gisp_pkg::gisp_state_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rd_reg, rd_next;          // current transfer is a read
  logic cmd_seen_reg, cmd_seen_next;
  logic wdone_reg, wdone_next;    // first data byte already taken
  logic ack_reg, ack_next;        // we acknowledge in this ack slot
  logic sda_oe_reg, sda_oe_next;
  gisp_pkg::gisp_cmd_t cmd_reg, cmd_next;
  logic [gisp_pkg::TMO_W-1:0] tmo_reg, tmo_next;
  logic rel_reg, rel_next;
  logic sleep_reg, sleep_next;

  // ----------------------------------------------------------------
  // line conditioning
  // ----------------------------------------------------------------
  gisp_line_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_line(line)
  );

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = p + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // next-state logic for transfer, pointer and drive
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    ptr_next = ptr_reg;
    rd_next = rd_reg;
    cmd_seen_next = cmd_seen_reg;
    wdone_next = wdone_reg;
    ack_next = ack_reg;
    sda_oe_next = sda_oe_reg;
    cmd_next = cmd_reg;
    cmd_next.wr = 1'b0;
    if (line.stop || rel_reg) begin
      st_next = gisp_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (line.start) begin
      st_next = gisp_pkg::ST_ADDR;  // also a repeated start
      bit_next = gisp_pkg::BITCNT_RST;
      sda_oe_next = 1'b0;
      wdone_next = 1'b0;
    end else begin
      unique case (st_reg)
        gisp_pkg::ST_IDLE: begin
          sda_oe_next = 1'b0;
        end
        gisp_pkg::ST_ADDR, gisp_pkg::ST_WRX: begin
          if (line.scl_rise) begin
            sh_next = {sh_reg[6:0], line.sda};
            bit_next = bit_reg + 4'h1;
          end
          if (line.scl_fall && bit_reg == 4'h8) begin
            bit_next = gisp_pkg::BITCNT_RST;
            st_next = gisp_pkg::ST_ACK;
            ack_next = 1'b0;
            if (st_reg == gisp_pkg::ST_ADDR) begin
              if (sh_reg[7:1] == gisp_pkg::SLAVE_ADDR) begin
                ack_next = 1'b1;
                rd_next = sh_reg[0];
                cmd_seen_next = 1'b0;
              end
            end else if (!cmd_seen_reg) begin
              // command byte sets the pointer
              ptr_next = sh_reg;
              cmd_seen_next = 1'b1;
              ack_next = (sh_reg <= gisp_pkg::CMD_READ_MAX);
            end else if (!wdone_reg && !i_ro) begin
              cmd_next.addr = ptr_reg;  // one-byte write
              cmd_next.wdata = sh_reg;
              cmd_next.wr = 1'b1;
              ptr_next = ptr_inc(ptr_reg);
              wdone_next = 1'b1;
              ack_next = 1'b1;
            end else begin
              wdone_next = 1'b1;  // extra or read-only data refused
            end
            sda_oe_next = ack_next;
            if (!ack_next) begin
              st_next = gisp_pkg::ST_HOLD;
            end
          end
        end
        gisp_pkg::ST_ACK: begin
          // release after the ack clock; reads load data at pointer
          if (line.scl_fall) begin
            if (rd_reg) begin
              sh_next = i_rdata;  // quick read at pointer
              st_next = gisp_pkg::ST_TX;
              sda_oe_next = ~i_rdata[7];
              bit_next = 4'h1;
            end else begin
              st_next = gisp_pkg::ST_WRX;
              sda_oe_next = 1'b0;
            end
          end
        end
        gisp_pkg::ST_TX: begin
          if (line.scl_fall) begin
            if (bit_reg == 4'h8) begin
              st_next = gisp_pkg::ST_MACK;
              sda_oe_next = 1'b0;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              sda_oe_next = ~sh_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        gisp_pkg::ST_MACK: begin
          if (line.scl_rise) begin
            if (!line.sda) begin
              ptr_next = ptr_inc(ptr_reg);  // master ack advances
              st_next = gisp_pkg::ST_ACK;  // incremental read
            end else begin
              st_next = gisp_pkg::ST_HOLD;  // master NACK ends read
            end
          end
        end
        gisp_pkg::ST_HOLD: begin
          if (line.scl_fall) begin
            sda_oe_next = 1'b0;
          end
        end
        default: begin
          st_next = gisp_pkg::ST_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // stuck-bus watchdog
  // ----------------------------------------------------------------
  // counts continuous low on either line
  always_comb begin
    tmo_next = tmo_reg;
    rel_next = rel_reg;
    sleep_next = sleep_reg;
    if (line.scl && line.sda) begin
      tmo_next = '0;
      rel_next = 1'b0;
      sleep_next = 1'b0;
    end else if (rel_reg) begin
      sleep_next = 1'b1;  // still low after release
    end else if (tmo_reg == TMO_W'(TIMEOUT_CYC - 1)) begin
      rel_next = 1'b1;  // release the data line
    end else begin
      tmo_next = tmo_reg + 1'b1;
    end
  end

  // engine registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= gisp_pkg::ST_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= gisp_pkg::BITCNT_RST;
      ptr_reg <= gisp_pkg::PTR_RST;
      rd_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
      wdone_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      ptr_reg <= ptr_next;
      rd_reg <= rd_next;
      cmd_seen_reg <= cmd_seen_next;
      wdone_reg <= wdone_next;
      ack_reg <= ack_next;
      sda_oe_reg <= sda_oe_next;
      cmd_reg <= cmd_next;
    end
  end

  // watchdog registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tmo_reg <= '0;
      rel_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else if (i_ce) begin
      tmo_reg <= tmo_next;
      rel_reg <= rel_next;
      sleep_reg <= sleep_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, from flops or constants
  // ----------------------------------------------------------------
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_reg;
  assign o_scl_out = 1'b0;
  assign o_scl_oe = 1'b0;  // no clock stretching
  assign o_cmd = cmd_reg;
  assign o_ptr = ptr_reg;
  assign o_sleep = sleep_reg;
  assign o_two_wire_mode = 1'b1;  // fixed two-wire mode
endmodule

// [gisp_slave_props.sv]
// concurrent checks on the pins of the two-wire slave port
`timescale 1ns/1ps
module gisp_slave_props #(
  parameter int TIMEOUT_CYC = 1000
) (
  // clock and control
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  // observed outputs
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire gisp_pkg::gisp_cmd_t o_cmd,
  input wire logic [7:0] o_ptr,
  input wire logic o_sleep,
  input wire logic o_two_wire_mode
);
  int low_reg;
  int low_next;
  // cycles since both lines were last seen high
  always_comb begin
    low_next = low_reg;
    if (i_scl && i_sda) low_next = 0;
    else if (i_ce) low_next = low_reg + 1;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) low_reg <= 0;
    else low_reg <= low_next;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_scl_never_held: assert property (o_scl_oe == 1'b0) else $error("clock line driven");
  a_wire_value: assert property (!o_sda_out && !o_scl_out) else $error("drive not low");
  a_mode_fixed: assert property (o_two_wire_mode) else $error("not two-wire mode");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed with clock high");
  a_oe_stands: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
    else $error("data drive too short");
  a_wr_single: assert property (o_cmd.wr |=> !o_cmd.wr [*8]) else $error("second write");
  a_wr_at_ptr: assert property (o_cmd.wr |-> ##[0:2] (o_ptr == o_cmd.addr + 8'h01))
    else $error("pointer not advanced after write");
  a_release_stuck: assert property (low_reg > TIMEOUT_CYC + 8 |-> !o_sda_oe)
    else $error("data line not released");
  a_sleep_late: assert property ($rose(o_sleep) |-> low_reg >= TIMEOUT_CYC)
    else $error("sleep before timeout");
endmodule
bind gisp_slave gisp_slave_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) gisp_slave_props_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
  .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_cmd(o_cmd), .o_ptr(o_ptr), .o_sleep(o_sleep), .o_two_wire_mode(o_two_wire_mode));

// [gisp_host_model.sv]
// two-wire bus master model on pulled-up open-drain lines
`timescale 1ns/1ps
module gisp_host_model (
  // clock and slave drive
  input wire logic i_clk,
  input wire logic i_sda_oe,
  // resolved line levels
  output logic o_scl,
  output logic o_sda
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  // pull-up wins unless someone pulls low
  assign o_scl = m_scl;
  assign o_sda = m_sda & ~i_sda_oe;
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // data moves only while clock low, sampled while high
  task bit_io(input logic b, output logic r);
    m_sda <= b;
    tick(8);
    m_scl <= 1'b1;
    tick(8);
    r = o_sda;
    tick(8);
    m_scl <= 1'b0;
    tick(8);
  endtask
  // start and repeated start alike
  task start();
    m_sda <= 1'b1;
    tick(8);
    m_scl <= 1'b1;
    tick(8);
    m_sda <= 1'b0;
    tick(8);
    m_scl <= 1'b0;
    tick(8);
  endtask
  task stop();
    m_sda <= 1'b0;
    tick(8);
    m_scl <= 1'b1;
    tick(8);
    m_sda <= 1'b1;
    tick(8);
  endtask
  // eight bits msb first, then the acknowledge bit
  task xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(last, a);
    ack = ~a;
  endtask
endmodule

// [gisp_slave_test.sv]
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module gisp_slave_test;
  localparam int TMO = 1000;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic scl;
  logic sda;
  logic sda_oe;
  logic sleep;
  logic [7:0] ptr;
  logic [3:0] fixed;
  logic [7:0] rdata;
  logic ro;
  gisp_pkg::gisp_cmd_t cmd;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [15:0] exp_q[$];
  logic [7:0] r;
  logic [7:0] c;
  logic [7:0] d;
  logic a;
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // command map: fixed pattern, 0x60..0x6F read-only
  assign rdata = ptr ^ 8'h5A;
  assign ro = (ptr[7:4] == 4'h6);
  gisp_host_model gisp_host_model_i (.i_clk(i_clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  gisp_slave #(.TIMEOUT_CYC(TMO)) gisp_slave_i (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1),
    .i_scl(scl), .i_sda(sda), .o_scl_out(fixed[3]), .o_scl_oe(fixed[2]),
    .o_sda_out(fixed[1]), .o_sda_oe(sda_oe),
    .i_rdata(rdata), .i_ro(ro), .o_cmd(cmd), .o_ptr(ptr), .o_sleep(sleep),
    .o_two_wire_mode(fixed[0]));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out();
    chk(16'(exp_q.size()), 16'h0000);
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wrb(input logic [7:0] b, input logic ack_exp);
    gisp_host_model_i.xfer(b, 1'b1, r, a);
    chk(16'(a), 16'(ack_exp));
  endtask
  task rdb(input logic nack, input logic [7:0] exp);
    gisp_host_model_i.xfer(8'hFF, nack, r, a);
    chk(16'(r), 16'(exp));
  endtask
  // scoreboard: every write pulse takes the oldest note
  always @(posedge i_clk) begin
    if (cmd.wr === 1'b1) begin
      if (exp_q.size() != 0) chk({cmd.addr, cmd.wdata}, exp_q.pop_front());
      else chk(16'(cmd.wr), 16'h0000);
    end
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'h7F16F2CF));
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(16'(fixed), 16'h0001);
    c = 8'($urandom_range(8'h5E, 8'h00));
    d = 8'($urandom());
    // one-byte write, extra byte refused
    gisp_host_model_i.start();
    wrb(8'hAA, 1'b1);
    wrb(c, 1'b1);
    exp_q.push_back({c, d});
    wrb(d, 1'b1);
    wrb(~d, 1'b0);
    gisp_host_model_i.stop();
    chk(16'(ptr), 16'(c + 8'h01));
    $display("test write done");
    // quick read from the pointer
    gisp_host_model_i.start();
    wrb(8'hAB, 1'b1);
    rdb(1'b0, (c + 8'h01) ^ 8'h5A);
    rdb(1'b1, (c + 8'h02) ^ 8'h5A);
    gisp_host_model_i.stop();
    chk(16'(ptr), 16'(c + 8'h02));
    $display("test quick read done");
    // incremental read ending at the top readable location
    gisp_host_model_i.start();
    wrb(8'hAA, 1'b1);
    wrb(8'h7E, 1'b1);
    gisp_host_model_i.start();
    wrb(8'hAB, 1'b1);
    rdb(1'b0, 8'h7E ^ 8'h5A);
    rdb(1'b1, 8'h7F ^ 8'h5A);
    gisp_host_model_i.stop();
    chk(16'(ptr), 16'h007F);
    $display("test incremental read done");
    // refused command bytes and foreign address
    for (int i = 0; i < 2; i++) begin
      gisp_host_model_i.start();
      wrb(8'hAA, 1'b1);
      wrb(i ? 8'hFF : 8'h80, 1'b0);
      gisp_host_model_i.stop();
    end
    gisp_host_model_i.start();
    wrb(8'hA8, 1'b0);
    gisp_host_model_i.stop();
    // data to a read-only location
    gisp_host_model_i.start();
    wrb(8'hAA, 1'b1);
    wrb({4'h6, d[3:0]}, 1'b1);
    wrb(d, 1'b0);
    gisp_host_model_i.stop();
    $display("test refusals done");
    // clock held low while the slave acknowledges
    gisp_host_model_i.start();
    c = 8'hAA;
    for (int i = 7; i >= 0; i--) gisp_host_model_i.bit_io(c[i], a);
    gisp_host_model_i.tick(TMO + 200);
    chk(16'(sda_oe), 16'h0000);
    chk(16'(sleep), 16'h0001);
    gisp_host_model_i.stop();
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    $display("test stuck bus done");
    repeat (10) @(posedge i_clk);
    // pointer and sleep back at reset values, quick read from there
    chk(16'(ptr), 16'(gisp_pkg::PTR_RST));
    chk(16'(sleep), 16'h0000);
    chk(16'(fixed), 16'h0001);
    gisp_host_model_i.start();
    wrb(8'hAB, 1'b1);
    rdb(1'b1, gisp_pkg::PTR_RST ^ 8'h5A);
    gisp_host_model_i.stop();
    $display("test read after reset done");
    close_out();
  end
endmodule
